// ### logic/pulse_channel.sv
// discrete output channel: discrete, momentary and continuous pulse modes
`timescale 1ns/1ps
`include "pulse_channel_defs.svh"
module pulse_channel
  import pulse_channel_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clock, // 25 MHz clock
  input wire logic rst, // sync reset, high
  input wire logic ce, // clock enable
  input wire logic [1:0] cfg_mode, // output mode
  input wire logic cfg_load, // new configuration strobe
  input wire logic [7:0] cfg_on_ms, // momentary pulse length, ms
  input wire logic [7:0] cfg_period_ms, // continuous period, ms
  input wire logic [7:0] cfg_init_pct, // initial on-time percent
  input wire logic cfg_fail_hold, // 1 hold last, 0 configured value
  input wire logic cfg_fail_value, // configured failure level
  input wire logic wr_valid, // value write strobe
  input wire logic wr_value, // discrete / momentary value
  input wire logic [7:0] wr_pct, // continuous on-time percent
  input wire logic comm_lost, // controller communication lost
  output logic out_q, // field output
  output logic pulse_busy // momentary pulse running
);
  // ==========================================
  // synchronised pin input
  // comm_lost arrives asynchronous to clock
  logic lost_s1_q;
  logic lost_s2_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      lost_s1_q <= 1'b0;
      lost_s2_q <= 1'b0;
    end else if (ce) begin
      lost_s1_q <= comm_lost;
      lost_s2_q <= lost_s1_q;
    end
  end
  // ==========================================
  // tick and state
  logic tick;
  ms_tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .tick(tick)
  );
  out_mode_t mode_q;
  mom_state_t mom_q;
  logic [7:0] mom_cnt_q;
  logic pend_q;
  logic last_val_q;
  logic [7:0] pct_q;
  logic [7:0] pct_pend_q;
  logic [7:0] period_q;
  logic [7:0] on_ms_q;
  logic [7:0] per_cnt_q;
  logic fail_q;
  // ==========================================
  // decode
  // percent values above full scale saturate
  function automatic logic [7:0] clamp_pct(input logic [7:0] pct);
    return (pct > `PERCENT_FULL) ? `PERCENT_FULL : pct;
  endfunction
  wire mode_change = cfg_load && (cfg_mode != mode_q);
  wire fail_enter = lost_s2_q && !fail_q;
  wire live_wr = wr_valid && !lost_s2_q;
  wire is_mom = (mode_q == mode_momentary);
  wire is_cont = (mode_q == mode_continuous);
  wire rise = live_wr && wr_value && !last_val_q;
  wire trig = is_mom && (rise || (mom_q == mom_idle && pend_q));
  wire [15:0] on_prod = 16'(pct_q) * 16'(period_q);
  wire [7:0] on_ms_cont = 8'(on_prod / 16'(`PERCENT_FULL));
  wire per_end = tick && (per_cnt_q + 8'h1 >= period_q);
  wire [7:0] period_clamp = (cfg_period_ms < `PERIOD_MIN_MS) ? `PERIOD_MIN_MS :
                            (cfg_period_ms > `PERIOD_MAX_MS) ? `PERIOD_MAX_MS :
                            cfg_period_ms;
  wire cont_level = (per_cnt_q < on_ms_cont);
  // pulse ends at the on_ms-th tick; the first tick may be partial
  wire mom_done = (mom_q == mom_pulse) && tick && (mom_cnt_q + 8'h1 >= on_ms_q);
  logic out_d;
  // failure outranks a mode change
  always_comb begin
    out_d = out_q;
    if (fail_q) begin
      out_d = out_q;
    end else if (fail_enter) begin
      out_d = cfg_fail_hold ? out_q : cfg_fail_value;
    end else if (mode_change) begin
      out_d = 1'b0;
    end else if (mode_q == mode_discrete) begin
      out_d = live_wr ? wr_value : out_q;
    end else if (is_mom) begin
      out_d = (mom_q == mom_pulse && !mom_done) ||
              (mom_q == mom_idle && trig && on_ms_q != 8'h0);
    end else if (is_cont) begin
      out_d = cont_level;
    end
  end
  // ==========================================
  // output and failure state
  always_ff @(posedge clock) begin
    if (rst) begin
      out_q <= `OUT_RESET;
      fail_q <= 1'b0;
      last_val_q <= 1'b0;
    end else if (ce) begin
      out_q <= out_d;
      fail_q <= lost_s2_q;
      if (mode_change) begin
        last_val_q <= 1'b0;
      end else if (live_wr) begin
        last_val_q <= wr_value;
      end
    end
  end
  // ==========================================
  // configuration
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q <= mode_discrete;
      on_ms_q <= 8'h0;
      period_q <= `PERIOD_MIN_MS;
    end else if (ce && cfg_load) begin
      mode_q <= out_mode_t'(cfg_mode);
      on_ms_q <= cfg_on_ms;
      period_q <= period_clamp;
    end
  end
  // ==========================================
  // momentary pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      mom_q <= mom_idle;
      mom_cnt_q <= 8'h0;
      pend_q <= 1'b0;
    end else if (ce) begin
      if (mode_change || fail_q || fail_enter) begin
        mom_q <= mom_idle;
        mom_cnt_q <= 8'h0;
        pend_q <= 1'b0;
      end else begin
        case (mom_q)
          mom_idle: begin
            pend_q <= 1'b0;
            if (trig && on_ms_q != 8'h0) begin
              mom_q <= mom_pulse;
              mom_cnt_q <= 8'h0;
            end
          end
          mom_pulse: begin
            if (rise) begin
              pend_q <= 1'b1;
            end
            if (mom_done) begin
              mom_q <= mom_idle;
            end else if (tick) begin
              mom_cnt_q <= mom_cnt_q + 8'h1;
            end
          end
          default: mom_q <= mom_idle;
        endcase
      end
    end
  end
  // ==========================================
  // continuous pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      per_cnt_q <= 8'h0;
      pct_q <= 8'h0;
      pct_pend_q <= 8'h0;
    end else if (ce) begin
      if (cfg_load) begin
        per_cnt_q <= 8'h0;
        pct_q <= clamp_pct(cfg_init_pct);
        pct_pend_q <= clamp_pct(cfg_init_pct);
      end else begin
        if (live_wr && is_cont) begin
          pct_pend_q <= clamp_pct(wr_pct);
        end
        if (per_end) begin
          per_cnt_q <= 8'h0;
          pct_q <= pct_pend_q;
        end else if (tick) begin
          per_cnt_q <= per_cnt_q + 8'h1;
        end
      end
    end
  end
  assign pulse_busy = (mom_q == mom_pulse);
  // ==========================================
  // pulse length bookkeeping for checks
  // cycles spent in the current pulse, and its length at start
  logic [31:0] busy_cyc_q;
  logic [7:0] len_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_cyc_q <= 32'h0;
      len_q <= 8'h0;
    end else if (ce) begin
      if (mom_q == mom_pulse) begin
        busy_cyc_q <= busy_cyc_q + 32'h1;
      end else begin
        busy_cyc_q <= 32'h0;
        len_q <= on_ms_q;
      end
    end
  end
  wire [31:0] len_max = 32'(len_q) * 32'(TICK_CYCLES);
  wire [31:0] len_min = 32'(on_ms_q - 8'h1) * 32'(TICK_CYCLES);
  // ==========================================
  // checks
  chk_mode_change_off: assert property (@(posedge clock) disable iff (rst)
    ce && mode_change && !lost_s2_q && !fail_q |=> !out_q)
    else $error("output not off after mode change");
  chk_discrete_follow: assert property (@(posedge clock) disable iff (rst)
    ce && mode_q == mode_discrete && live_wr && !cfg_load && !fail_q && !fail_enter
    |=> out_q == $past(wr_value))
    else $error("discrete output did not follow write");
  chk_fail_hold: assert property (@(posedge clock) disable iff (rst)
    ce && fail_q |=> $stable(out_q))
    else $error("output moved during failure");
  chk_fail_value: assert property (@(posedge clock) disable iff (rst)
    ce && fail_enter && !cfg_fail_hold |=> out_q == $past(cfg_fail_value))
    else $error("failure value not driven");
  chk_pulse_start: assert property (@(posedge clock) disable iff (rst)
    ce && mom_q == mom_idle && trig && on_ms_q != 8'h0 && !mode_change && !fail_q
    && !fail_enter |=> out_q && pulse_busy)
    else $error("momentary pulse did not start");
  chk_pulse_keep: assert property (@(posedge clock) disable iff (rst)
    ce && pulse_busy && rise && !mode_change && !fail_enter |=> pulse_busy || pend_q)
    else $error("new value lost during pulse");
  chk_pct_apply: assert property (@(posedge clock) disable iff (rst)
    ce && !cfg_load && !per_end |=> pct_q == $past(pct_q))
    else $error("on-time changed mid period");
  chk_period_range: assert property (@(posedge clock) disable iff (rst)
    period_q >= `PERIOD_MIN_MS && period_q <= `PERIOD_MAX_MS)
    else $error("period out of range");
  chk_zero_pct: assert property (@(posedge clock) disable iff (rst)
    ce && is_cont && pct_q == 8'h0 && !fail_q && !fail_enter && !cfg_load |=> !out_q)
    else $error("zero on-time gave a pulse");
  // ==========================================
  // checks: discrete, failure, reset and enable
  chk_discrete_hold: assert property (@(posedge clock) disable iff (rst)
    ce && mode_q == mode_discrete && !live_wr && !cfg_load && !fail_enter |=> $stable(out_q))
    else $error("discrete output moved without a write");
  chk_fail_enter_hold: assert property (@(posedge clock) disable iff (rst)
    ce && fail_enter && cfg_fail_hold |=> $stable(out_q))
    else $error("hold mode changed output on failure");
  chk_fail_abort: assert property (@(posedge clock) disable iff (rst)
    ce && fail_enter |=> !pulse_busy)
    else $error("pulse kept running in failure");
  chk_reset_off: assert property (@(posedge clock)
    rst |=> !out_q && !pulse_busy)
    else $error("reset did not clear output");
  chk_ce_freeze: assert property (@(posedge clock) disable iff (rst)
    !ce |=> $stable(out_q) && $stable(mom_q) && $stable(per_cnt_q))
    else $error("state moved with enable low");
  // ==========================================
  // checks: momentary
  chk_pulse_end: assert property (@(posedge clock) disable iff (rst)
    ce && is_mom && mom_done && !mode_change && !fail_q && !fail_enter |=> !out_q)
    else $error("output not off at pulse end");
  chk_pend_start: assert property (@(posedge clock) disable iff (rst)
    ce && is_mom && mom_q == mom_idle && pend_q && on_ms_q != 8'h0
    && !mode_change && !fail_q && !fail_enter |=> pulse_busy)
    else $error("pended pulse did not start");
  chk_pulse_max: assert property (@(posedge clock) disable iff (rst)
    pulse_busy |-> busy_cyc_q < len_max)
    else $error("pulse longer than configured");
  chk_pulse_min: assert property (@(posedge clock) disable iff (rst)
    mom_done && on_ms_q == len_q |-> busy_cyc_q >= len_min)
    else $error("pulse shorter than configured");
  chk_zero_len: assert property (@(posedge clock) disable iff (rst)
    ce && is_mom && on_ms_q == 8'h0 && !pulse_busy |=> !pulse_busy)
    else $error("zero length gave a pulse");
  // ==========================================
  // checks: continuous
  chk_init_pct: assert property (@(posedge clock) disable iff (rst)
    ce && cfg_load |=> pct_q == clamp_pct($past(cfg_init_pct)))
    else $error("initial on-time not loaded");
  chk_pend_latch: assert property (@(posedge clock) disable iff (rst)
    ce && is_cont && live_wr && !cfg_load |=> pct_pend_q == clamp_pct($past(wr_pct)))
    else $error("new on-time not kept pending");
  chk_cont_on: assert property (@(posedge clock) disable iff (rst)
    ce && is_cont && !cfg_load && !fail_q && !fail_enter
    |=> out_q == $past(per_cnt_q < on_ms_cont))
    else $error("continuous level wrong");
  chk_per_bound: assert property (@(posedge clock) disable iff (rst)
    per_cnt_q < period_q)
    else $error("period counter past period");
  chk_per_wrap: assert property (@(posedge clock) disable iff (rst)
    ce && per_end && !cfg_load |=> per_cnt_q == 8'h0)
    else $error("period counter did not wrap");
  // ==========================================
  // coverage
  cov_mom_pulse: cover property (@(posedge clock) disable iff (rst) mom_done);
  cov_cont_wrap: cover property (@(posedge clock) disable iff (rst) is_cont && per_end);
  cov_fail: cover property (@(posedge clock) disable iff (rst) fail_enter);
  cov_pend_restart: cover property (@(posedge clock) disable iff (rst)
    is_mom && pend_q && mom_q == mom_idle);
  cov_ce_hold: cover property (@(posedge clock) disable iff (rst) !ce && out_q);
endmodule

// ### shared/pulse_channel_defs.svh
// constants for the discrete output pulse channel
// Operation
// - mode type change forces output off
// - momentary true write gives one pulse
// - running pulse completes before new value
// - pulse length in ms, 0-to-1 trigger
// - continuous mode on for percent of period
// - on-time first, then off for remainder
// - new on-time applies at period end
// - hold mode freezes output at failure
// - failure value mode drives configured level
// - initial on-time used until first command
// - period configurable 2 to 200 ms
`ifndef PULSE_CHANNEL_DEFS_SVH
`define PULSE_CHANNEL_DEFS_SVH
// ==========================================
// timing
`define CLK_FREQ_HZ 25000000
`define TICK_TIME_MS 1
`define TICK_CYCLES ((`CLK_FREQ_HZ / 1000) * `TICK_TIME_MS)
`define PERIOD_MIN_MS 8'h02
`define PERIOD_MAX_MS 8'hC8
`define PERCENT_FULL 8'h64
// ==========================================
// encodings
`define MODE_DISCRETE 2'h0
`define MODE_MOMENTARY 2'h1
`define MODE_CONTINUOUS 2'h2
`define OUT_RESET 1'h0
`endif

// ### shared/pulse_channel_pkg.sv
// types for the discrete output pulse channel
package pulse_channel_pkg;
  typedef enum logic [1:0] {
    mode_discrete = 2'b00,
    mode_momentary = 2'b01,
    mode_continuous = 2'b10
  } out_mode_t;
  typedef enum logic [1:0] {
    mom_idle = 2'b00,
    mom_pulse = 2'b01
  } mom_state_t;
endpackage

// ### logic/ms_tick_gen.sv
// millisecond tick generator
`timescale 1ns/1ps
`include "pulse_channel_defs.svh"
module ms_tick_gen #(
  parameter int unsigned CYCLES = `TICK_CYCLES
) (
  input wire logic clock, // system clock
  input wire logic rst, // sync reset
  input wire logic ce, // clock enable
  output logic tick // one-cycle ms pulse
);
  logic [31:0] cnt_q;
  wire wrap = (cnt_q == 32'(CYCLES - 1));
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q <= 32'h0;
    end else if (ce) begin
      cnt_q <= wrap ? 32'h0 : cnt_q + 32'h1;
    end
  end
  assign tick = ce & wrap;
endmodule

// ### testbench/controller_model.sv
// system controller model: configuration loads, value writes, link state
`timescale 1ns/1ps
module controller_model (
  input wire logic clock, // system clock
  output logic [1:0] cfg_mode, // output mode
  output logic cfg_load, // configuration strobe
  output logic [7:0] cfg_on_ms, // pulse length
  output logic [7:0] cfg_period_ms, // period
  output logic [7:0] cfg_init_pct, // initial percent
  output logic cfg_fail_hold, // hold on failure
  output logic cfg_fail_value, // failure level
  output logic wr_valid, // write strobe
  output logic wr_value, // value
  output logic [7:0] wr_pct, // on-time percent
  output logic comm_lost // link lost
);
  initial begin
    {cfg_mode, cfg_load, cfg_on_ms, cfg_period_ms, cfg_init_pct} = '0;
    {cfg_fail_hold, cfg_fail_value, wr_valid, wr_value, wr_pct, comm_lost} = '0;
  end
  // each cfg or wr request is held over one taking edge, released, then one idle edge
  task automatic cfg(input logic [1:0] m, input logic [7:0] on, per, pct);
    cfg_mode = m;
    cfg_on_ms = on;
    cfg_period_ms = per;
    cfg_init_pct = pct;
    cfg_load = 1'b1;
    @(posedge clock) #1;
    cfg_load = 1'b0;
    cfg_mode = ~m;
    @(posedge clock) #1;
  endtask
  task automatic wr(input logic v, input logic [7:0] pct);
    wr_value = v;
    wr_pct = pct;
    wr_valid = 1'b1;
    @(posedge clock) #1;
    wr_valid = 1'b0;
    wr_value = ~v;
    wr_pct = ~pct;
    @(posedge clock) #1;
  endtask
  task automatic fail(input logic hold, val, lost);
    cfg_fail_hold = hold;
    cfg_fail_value = val;
    comm_lost = lost;
  endtask
endmodule

// ### testbench/pulse_channel_bench.sv
// self-checking bench for the pulse channel
`timescale 1ns/1ps
module pulse_channel_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [1:0] cfg_mode;
  logic cfg_load, cfg_fail_hold, cfg_fail_value, wr_valid, wr_value, comm_lost;
  logic [7:0] cfg_on_ms, cfg_period_ms, cfg_init_pct, wr_pct;
  logic out_q, pulse_busy, probe = 1'b0;
  logic [1:0] exp_q[$];
  int error_cnt = 0, cmp_count = 0, seed = 78, cyc = 0, t0, n;
  always #20 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  controller_model controller_model_i (.clock(clock), .cfg_mode(cfg_mode),
    .cfg_load(cfg_load), .cfg_on_ms(cfg_on_ms), .cfg_period_ms(cfg_period_ms),
    .cfg_init_pct(cfg_init_pct), .cfg_fail_hold(cfg_fail_hold),
    .cfg_fail_value(cfg_fail_value), .wr_valid(wr_valid), .wr_value(wr_value),
    .wr_pct(wr_pct), .comm_lost(comm_lost));
  pulse_channel #(.TICK_CYCLES(4)) pulse_channel_i (.clock(clock), .rst(rst),
    .ce(ce), .cfg_mode(cfg_mode), .cfg_load(cfg_load), .cfg_on_ms(cfg_on_ms),
    .cfg_period_ms(cfg_period_ms), .cfg_init_pct(cfg_init_pct),
    .cfg_fail_hold(cfg_fail_hold), .cfg_fail_value(cfg_fail_value),
    .wr_valid(wr_valid), .wr_value(wr_value), .wr_pct(wr_pct),
    .comm_lost(comm_lost), .out_q(out_q), .pulse_busy(pulse_busy));
  // ==========================================
  // compare and report
  task automatic compare_state(input logic [1:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t out/busy %b expected %b", $time, got, exp);
    end
  endtask
  task automatic compare_cnt(input int got, lo, hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("CHECK FAILED %0t count %0d expected %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // monitor takes oldest note when a probe appears, mid-cycle where outputs are settled
  always @(negedge clock) begin
    if (probe) begin
      compare_state({out_q, pulse_busy}, exp_q.pop_front());
    end
  end
  task automatic chk(input logic [1:0] e);
    exp_q.push_back(e);
    probe = 1'b1;
    @(posedge clock) #1;
    probe = 1'b0;
  endtask
  task automatic wait_busy(input logic v);
    t0 = cyc;
    while (pulse_busy !== v && cyc - t0 < 40) @(posedge clock) #1;
  endtask
  // high cycles over a window after a settling span
  task automatic count_on(input int settle, win);
    repeat (settle) @(posedge clock);
    n = 0;
    repeat (win) @(posedge clock) n += (out_q === 1'b1);
    #1;
  endtask
  task automatic lose(input logic hold, val);
    controller_model_i.fail(hold, val, 1'b1);
    repeat (4) @(posedge clock) #1;
  endtask
  initial begin
    #(40 * 5000);
    error_cnt++;
    results();
  end
  // ==========================================
  // scenarios
  initial begin
    logic v;
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    chk(2'b00);
    repeat (8) begin
      v = $random(seed);
      controller_model_i.wr(v, 8'h00);
      chk({v, 1'b0});
    end
    controller_model_i.wr(1'b1, 8'h00);
    controller_model_i.cfg(2'h1, 8'h03, 8'h0A, 8'h00);
    chk(2'b00);
    controller_model_i.wr(1'b1, 8'h00);
    t0 = cyc;
    chk(2'b11);
    controller_model_i.wr(1'b0, 8'h00);
    controller_model_i.wr(1'b1, 8'h00);
    n = t0;
    wait_busy(1'b0);
    compare_cnt(cyc - n, 8, 11);
    wait_busy(1'b1);
    compare_cnt(cyc - t0, 1, 1);
    wait_busy(1'b0);
    chk(2'b00);
    controller_model_i.cfg(2'h2, 8'h00, 8'h0A, 8'h1E);
    count_on(40, 40);
    compare_cnt(n, 12, 12);
    controller_model_i.wr(1'b0, 8'h46);
    count_on(80, 40);
    compare_cnt(n, 28, 28);
    controller_model_i.cfg(2'h2, 8'h00, 8'h01, 8'h32);
    count_on(16, 8);
    compare_cnt(n, 4, 4);
    controller_model_i.cfg(2'h2, 8'h00, 8'h0A, 8'h00);
    count_on(40, 40);
    compare_cnt(n, 0, 0);
    controller_model_i.cfg(2'h0, 8'h00, 8'h0A, 8'h00);
    controller_model_i.wr(1'b1, 8'h00);
    ce = 1'b0;
    controller_model_i.wr(1'b0, 8'h00);
    chk(2'b10);
    ce = 1'b1;
    lose(1'b1, 1'b0);
    controller_model_i.wr(1'b0, 8'h00);
    chk(2'b10);
    controller_model_i.fail(1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge clock) #1;
    controller_model_i.wr(1'b0, 8'h00);
    lose(1'b0, 1'b1);
    chk(2'b10);
    controller_model_i.fail(1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge clock) #1;
    controller_model_i.wr(1'b1, 8'h00);
    lose(1'b0, 1'b0);
    chk(2'b00);
    results();
  end
endmodule
